// ===== core/tcx_pkg.sv
// Shared constants and carrier types of the transfer controller control block.
package tcx_pkg;
	localparam int TCX_NUM_REGS = 8;
	localparam int TCX_REG_W = 16;
	localparam int TCX_NUM_SRC = TCX_NUM_REGS * TCX_REG_W;
	localparam int TCX_SRC_W = 7;
	localparam int TCX_CNT_W = 16;
	// Byte offsets of the register map.
	localparam logic [7:0] TCX_OFS_ENABLE_A = 8'h00;
	localparam logic [7:0] TCX_OFS_ENABLE_H = 8'h1C;
	localparam logic [7:0] TCX_OFS_CONTROL = 8'h20;
	localparam logic [7:0] TCX_ADDR_MASK = 8'hFF;
	// Field positions of the control register.
	localparam int TCX_CTL_SKIP_BIT = 4;
	localparam int TCX_CTL_CHAIN_BIT = 3;
	localparam int TCX_CTL_STOP_BIT = 0;
	localparam logic [15:0] TCX_ENABLE_RESET = 16'h0000;
	localparam logic [7:0] TCX_CONTROL_RESET = 8'h00;
	localparam logic [15:0] TCX_CNT_ONE = 16'h0001;
	localparam logic [1:0] TCX_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] TCX_HRESP_OKAY = 2'h0;

	typedef enum logic [1:0] {
		TCX_MODE_NORMAL = 2'h0,
		TCX_MODE_REPEAT = 2'h1,
		TCX_MODE_BLOCK = 2'h2
	} tcx_mode_e;

	// Activation handed to the transfer engine.
	typedef struct packed {
		logic [TCX_SRC_W-1:0] vector;
		logic fetchInfo;
	} tcx_act_s;

	// Transfer information loaded by the engine after a fetch.
	typedef struct packed {
		tcx_mode_e mode;
		logic everyIrq;
		logic [TCX_CNT_W-1:0] blockCount;
	} tcx_info_s;

	// Report of one finished data transfer.
	typedef struct packed {
		logic countEnd;
		logic chainNext;
		logic repeatReload;
	} tcx_done_s;
endpackage

// ===== core/tcx_transfer_ctrl.sv
// Activation, block counting, read skip and control registers of the transfer controller.
`timescale 1ns/1ps
module tcx_transfer_ctrl
	import tcx_pkg::*;
(
	input wire logic mclk, // System clock.
	input wire logic nrst, // Asynchronous reset, active low.
	input wire logic hsel, // AHB slave select.
	input wire logic [31:0] haddr, // AHB address.
	input wire logic [1:0] htrans, // AHB transfer type.
	input wire logic hwrite, // AHB write flag.
	input wire logic [2:0] hsize, // AHB transfer size.
	input wire logic [31:0] hwdata, // AHB write data.
	input wire logic hready, // AHB bus ready.
	output logic [31:0] hrdata, // AHB read data.
	output logic hreadyout, // AHB slave ready.
	output logic [1:0] hresp, // AHB response.
	input wire logic [TCX_NUM_SRC-1:0] srcReq, // Interrupt source levels.
	output logic [TCX_NUM_SRC-1:0] cpuSrcReq, // Sources passed to the CPU.
	output logic actValid, // Activation offered to the engine.
	input wire logic actReady, // Engine accepts the activation.
	output tcx_act_s actInfo, // Vector and fetch decision.
	input wire logic infoLoad, // Engine loaded transfer information.
	input wire tcx_info_s infoData, // Loaded transfer information.
	input wire logic doneValid, // One data transfer finished.
	input wire tcx_done_s doneData, // Details of the finished transfer.
	output logic chainAllow, // Engine may run the chained transfer.
	input wire logic addrError, // Address error event.
	input wire logic nmiEvent, // Non-maskable interrupt event.
	output logic xferHalt, // Transfer activity stopped.
	output logic cpuIrq, // Completion interrupt pulse.
	output logic [TCX_SRC_W-1:0] cpuIrqVector // Source of the completion interrupt.
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ISSUE = 4'b0010,
		ST_BUSY = 4'b0100,
		ST_IRQ = 4'b1000
	} tcx_state_e;

	tcx_state_e stateReg, stateNext;
	logic [TCX_REG_W-1:0] enableReg [TCX_NUM_REGS];
	logic [TCX_REG_W-1:0] readOneReg [TCX_NUM_REGS];
	logic [7:0] controlReg;
	logic stopReadOneReg;
	logic [TCX_CNT_W-1:0] blockCountReg;
	tcx_mode_e modeReg;
	logic everyIrqReg;
	logic [TCX_SRC_W-1:0] curSrcReg;
	logic [TCX_SRC_W-1:0] prevVectorReg;
	logic prevValidReg;
	logic prevChainReg;
	logic fetchReg;
	logic irqReg;
	logic [TCX_SRC_W-1:0] irqVectorReg;
	logic [31:0] hrdataReg;
	logic wrPendReg;
	logic [7:0] wrAddrReg;

	// Bus decode.
	wire logic busAccess = hsel & hready & (htrans == TCX_HTRANS_NONSEQ);
	wire logic busRead = busAccess & ~hwrite;
	wire logic [7:0] addrLow = haddr[7:0] & TCX_ADDR_MASK;
	wire logic rdEnableHit = (addrLow <= TCX_OFS_ENABLE_H) & (addrLow[1:0] == 2'h0);
	wire logic rdControlHit = (addrLow == TCX_OFS_CONTROL);
	wire logic [2:0] rdIndex = addrLow[4:2];
	wire logic wrEnableHit = wrPendReg & (wrAddrReg <= TCX_OFS_ENABLE_H)
		& (wrAddrReg[1:0] == 2'h0);
	wire logic wrControlHit = wrPendReg & (wrAddrReg == TCX_OFS_CONTROL);
	wire logic [2:0] wrIndex = wrAddrReg[4:2];

	// Control fields.
	wire logic skipEnable = controlReg[TCX_CTL_SKIP_BIT];
	wire logic chainRepeatEnable = controlReg[TCX_CTL_CHAIN_BIT];
	wire logic stopFlag = controlReg[TCX_CTL_STOP_BIT];
	wire logic stopEvent = addrError | nmiEvent;

	// Flattened enables and source choice; lowest index wins.
	logic [TCX_NUM_SRC-1:0] enableFlat;
	logic [TCX_NUM_SRC-1:0] activeReq;
	logic [TCX_SRC_W-1:0] pickSrc;
	logic pickAny;

	always_comb begin
		pickSrc = '0;
		pickAny = 1'b0;
		for (int i = TCX_NUM_SRC - 1; i >= 0; i--) begin
			if (activeReq[i]) begin
				pickSrc = TCX_SRC_W'(i);
				pickAny = 1'b1;
			end
		end
	end

	assign cpuSrcReq = srcReq & ~enableFlat;
	assign activeReq = srcReq & enableFlat;

	// Completion decision for the finished transfer.
	wire logic blockLast = (modeReg == TCX_MODE_BLOCK) & (blockCountReg == TCX_CNT_ONE);
	wire logic countEnded = (modeReg == TCX_MODE_BLOCK) ? blockLast : doneData.countEnd;
	wire logic doneUsed = (stateReg == ST_BUSY) & doneValid;
	wire logic doneFinal = doneUsed & ~doneData.chainNext;
	wire logic clearEnable = doneFinal & (everyIrqReg | countEnded);
	wire logic raiseIrq = clearEnable;

	wire logic skipFetch = skipEnable & prevValidReg & ~prevChainReg
		& (prevVectorReg == pickSrc);

	assign chainAllow = doneData.chainNext
		& (~(modeReg == TCX_MODE_REPEAT) | ~doneData.repeatReload | chainRepeatEnable);

	always_comb begin
		stateNext = stateReg;
		unique case (stateReg)
			ST_IDLE: begin
				if (pickAny & ~stopFlag) begin
					stateNext = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				if (stopFlag) begin
					stateNext = ST_IDLE;
				end else if (actReady) begin
					stateNext = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (stopFlag | stopEvent) begin
					stateNext = ST_IDLE;
				end else if (doneFinal) begin
					stateNext = raiseIrq ? ST_IRQ : ST_IDLE;
				end
			end
			ST_IRQ: begin
				stateNext = ST_IDLE;
			end
		endcase
	end

	assign actValid = (stateReg == ST_ISSUE) & ~stopFlag;
	assign actInfo.vector = curSrcReg;
	assign actInfo.fetchInfo = fetchReg;
	assign xferHalt = stopFlag;
	assign cpuIrq = irqReg;
	assign cpuIrqVector = irqVectorReg;
	assign hrdata = hrdataReg;
	assign hreadyout = 1'b1;
	assign hresp = TCX_HRESP_OKAY;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stateReg <= ST_IDLE;
		end else begin
			stateReg <= stateNext;
		end
	end

	// Activation capture and read-skip history.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			curSrcReg <= '0;
			fetchReg <= 1'b1;
			prevVectorReg <= '0;
			prevValidReg <= 1'b0;
			prevChainReg <= 1'b0;
		end else begin
			if (stateReg == ST_IDLE) begin
				curSrcReg <= pickSrc;
				fetchReg <= ~skipFetch;
			end
			if ((stateReg == ST_ISSUE) & actReady & ~stopFlag) begin
				prevVectorReg <= curSrcReg;
				prevValidReg <= 1'b1;
				prevChainReg <= 1'b0;
			end
			if (doneUsed & doneData.chainNext) begin
				prevChainReg <= 1'b1;
			end
		end
	end

	// Transfer information and the hidden block counter.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			modeReg <= TCX_MODE_NORMAL;
			everyIrqReg <= 1'b0;
			blockCountReg <= '0;
		end else if (infoLoad) begin
			modeReg <= infoData.mode;
			everyIrqReg <= infoData.everyIrq;
			blockCountReg <= infoData.blockCount;
		end else if (doneUsed & (modeReg == TCX_MODE_BLOCK)) begin
			blockCountReg <= blockCountReg - TCX_CNT_ONE;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irqReg <= 1'b0;
			irqVectorReg <= '0;
		end else begin
			irqReg <= (stateReg == ST_IRQ);
			if (stateReg == ST_IRQ) begin
				irqVectorReg <= curSrcReg;
			end
		end
	end

	// Bus address phase: read data and write capture.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hrdataReg <= '0;
			wrPendReg <= 1'b0;
			wrAddrReg <= '0;
		end else begin
			wrPendReg <= busAccess & hwrite;
			if (busAccess) begin
				wrAddrReg <= addrLow;
			end
			if (busRead) begin
				if (rdEnableHit) begin
					hrdataReg <= {16'h0000, enableReg[rdIndex]};
				end else if (rdControlHit) begin
					hrdataReg <= {24'h000000, 3'h0, controlReg[4:0]};
				end else begin
					hrdataReg <= '0;
				end
			end
		end
	end

	// Enable registers, one per generate entry.
	genvar g;
	generate
		for (g = 0; g < TCX_NUM_REGS; g++) begin : genEnable
			wire logic rdHit = busRead & rdEnableHit & (rdIndex == 3'(g));
			wire logic wrHit = wrEnableHit & (wrIndex == 3'(g));
			wire logic [TCX_REG_W-1:0] wrData = hwdata[TCX_REG_W-1:0];
			wire logic [TCX_REG_W-1:0] hwClear = clearEnable
				& (curSrcReg[6:4] == 3'(g)) ? (16'h0001 << curSrcReg[3:0]) : 16'h0000;
			wire logic [TCX_REG_W-1:0] swClear = wrHit ? (~wrData & readOneReg[g]) : 16'h0000;
			wire logic [TCX_REG_W-1:0] swSet = wrHit ? wrData : 16'h0000;
			wire logic [TCX_REG_W-1:0] enableNext = ((enableReg[g] & ~swClear) | swSet) & ~hwClear;
			assign enableFlat[g*TCX_REG_W +: TCX_REG_W] = enableReg[g];
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					enableReg[g] <= TCX_ENABLE_RESET;
					readOneReg[g] <= '0;
				end else begin
					enableReg[g] <= enableNext;
					if (rdHit) begin
						readOneReg[g] <= enableReg[g];
					end else if (wrHit) begin
						readOneReg[g] <= '0;
					end
				end
			end
		end
	endgenerate

	// Control register; the stop flag's hardware set wins over a clear.
	wire logic stopClear = wrControlHit & ~hwdata[TCX_CTL_STOP_BIT] & stopReadOneReg;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			controlReg <= TCX_CONTROL_RESET;
			stopReadOneReg <= 1'b0;
		end else begin
			if (wrControlHit) begin
				controlReg[TCX_CTL_SKIP_BIT] <= hwdata[TCX_CTL_SKIP_BIT];
				controlReg[TCX_CTL_CHAIN_BIT] <= hwdata[TCX_CTL_CHAIN_BIT];
			end
			if (stopEvent) begin
				controlReg[TCX_CTL_STOP_BIT] <= 1'b1;
			end else if (stopClear) begin
				controlReg[TCX_CTL_STOP_BIT] <= 1'b0;
			end
			if (busRead & rdControlHit) begin
				stopReadOneReg <= stopFlag;
			end else if (wrControlHit) begin
				stopReadOneReg <= 1'b0;
			end
		end
	end
endmodule

// ===== tb/tcx_ctrl_props.sv
// Port-level checks of the transfer control block.
`timescale 1ns/1ps
module tcx_ctrl_props
	import tcx_pkg::*;
(
	input wire logic mclk, // Clock.
	input wire logic nrst, // Reset, low.
	input wire logic actValid, // Offer.
	input wire logic actReady, // Accept.
	input wire tcx_act_s actInfo, // Offer data.
	input wire logic doneValid, // Done.
	input wire tcx_done_s doneData, // Done data.
	input wire logic chainAllow, // Chain verdict.
	input wire logic addrError, // Bus fault.
	input wire logic nmiEvent, // NMI.
	input wire logic xferHalt, // Stop flag.
	input wire logic cpuIrq, // Irq pulse.
	input wire logic [TCX_SRC_W-1:0] cpuIrqVector // Irq source.
);
	logic seenAct;
	logic [TCX_SRC_W-1:0] lastVec;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// The completion source must be the last accepted vector.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			seenAct <= 1'b0;
			lastVec <= '0;
		end else if (actValid && actReady) begin
			seenAct <= 1'b1;
			lastVec <= actInfo.vector;
		end
	end
	AST_FIRST_FETCH: assert property ($rose(actValid) && !seenAct |-> actInfo.fetchInfo)
		else $error("first activation skipped its fetch");
	AST_HALT_SET: assert property (addrError || nmiEvent |=> xferHalt)
		else $error("stop flag not set by event");
	AST_NO_ACT_HALT: assert property ($rose(actValid) |-> !$past(xferHalt))
		else $error("activation offered while stopped");
	AST_ACT_HOLD: assert property (actValid && !actReady && !addrError && !nmiEvent
		|=> actValid && $stable(actInfo)) else $error("offer not held");
	AST_ACT_DROP: assert property (actValid && actReady |=> !actValid)
		else $error("offer kept after acceptance");
	AST_CHAIN_ON: assert property (doneValid && doneData.chainNext && !doneData.repeatReload
		|-> chainAllow) else $error("chain refused without reload");
	AST_IRQ_PULSE: assert property (cpuIrq |=> !cpuIrq)
		else $error("interrupt wider than one cycle");
	AST_IRQ_VEC: assert property (cpuIrq |-> cpuIrqVector == lastVec)
		else $error("interrupt source wrong");
	cover property (doneValid && doneData.chainNext && chainAllow);
	cover property (actValid && actReady && !actInfo.fetchInfo);
	cover property (cpuIrq);
endmodule
bind tcx_transfer_ctrl tcx_ctrl_props u_props (.mclk, .nrst, .actValid, .actReady, .actInfo,
	.doneValid, .doneData, .chainAllow, .addrError, .nmiEvent, .xferHalt, .cpuIrq, .cpuIrqVector);

// ===== tb/tcx_engine_model.sv
// Behavioural transfer engine answering the control block's activations.
`timescale 1ns/1ps
module tcx_engine_model
	import tcx_pkg::*;
(
	input wire logic mclk, // Clock.
	input wire logic nrst, // Reset, low.
	input wire logic actValid, // Offer.
	input wire tcx_act_s actInfo, // Offer data.
	input wire logic chainAllow, // Chain verdict.
	input wire tcx_info_s cfgInfo, // Info to load.
	input wire logic cfgChain, // Chain first.
	input wire logic cfgEnd, // Count end.
	output logic actReady, // Accept.
	output logic infoLoad, // Info pulse.
	output tcx_info_s infoData, // Info value.
	output logic doneValid, // Done pulse.
	output tcx_done_s doneData, // Done data.
	output logic chainSeen, // Sampled verdict.
	output int actCnt, // Accepted offers.
	output int fetchCnt, // Info loads.
	output int doneCnt // Final dones.
);
	initial begin
		{actReady, infoLoad, doneValid, chainSeen} = 4'h0;
		infoData = '0;
		doneData = '0;
		actCnt = 0;
		fetchCnt = 0;
		doneCnt = 0;
		forever begin
			@(posedge mclk);
			if (nrst && actValid) begin
				// Every other offer is accepted late so the held offer is exercised.
				if (actCnt[0]) repeat (2) @(posedge mclk);
				actReady <= 1'b1;
				@(posedge mclk);
				actReady <= 1'b0;
				actCnt++;
				if (actInfo.fetchInfo) begin
					fetchCnt++;
					infoLoad <= 1'b1;
					infoData <= cfgInfo;
					@(posedge mclk);
					infoLoad <= 1'b0;
					infoData <= tcx_info_s'(~cfgInfo);
				end
				doneValid <= 1'b1;
				if (cfgChain) begin
					doneData <= '{1'b0, 1'b1, cfgInfo.mode == TCX_MODE_REPEAT};
					@(posedge mclk);
					chainSeen = chainAllow;
				end
				doneData <= '{cfgEnd, 1'b0, 1'b0};
				@(posedge mclk);
				doneValid <= 1'b0;
				doneData <= tcx_done_s'(~doneData);
				doneCnt++;
			end
		end
	end
endmodule

// ===== tb/testbench.sv
// Self-checking bench of the transfer control block.
`timescale 1ns/1ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errTotal++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench
	import tcx_pkg::*;
;
	logic mclk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, addrError = 1'b0, nmiEvent = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0] htrans = 2'h0, hresp;
	logic [TCX_NUM_SRC-1:0] srcReq = '0, cpuSrcReq;
	logic hreadyout, actValid, actReady, infoLoad, doneValid, chainAllow, xferHalt, cpuIrq;
	logic cfgChain = 1'b0, cfgEnd = 1'b1, chainSeen;
	logic [7:0] ctlTab [5] = '{8'h10, 8'h00, 8'h10, 8'h00, 8'h18};
	logic [4:0] chnTab = 5'b11100, fetTab = 5'b11010, seeTab = 5'b10100;
	tcx_act_s actInfo;
	tcx_info_s infoData;
	tcx_info_s cfgInfo = '{TCX_MODE_NORMAL, 1'b1, 16'h0001};
	tcx_done_s doneData;
	logic [TCX_SRC_W-1:0] cpuIrqVector, irqVec = '0;
	int errTotal = 0, nCompared = 0, irqCnt = 0, actCnt, fetchCnt, doneCnt, a0, f0, i0;
	always #2 mclk = ~mclk;
	always @(posedge mclk) if (cpuIrq === 1'b1) begin
		irqCnt++;
		irqVec = cpuIrqVector;
	end
	tcx_transfer_ctrl i_dut (.mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .srcReq, .cpuSrcReq, .actValid, .actReady,
		.actInfo, .infoLoad, .infoData, .doneValid, .doneData, .chainAllow, .addrError, .nmiEvent,
		.xferHalt, .cpuIrq, .cpuIrqVector);
	tcx_engine_model i_eng (.mclk, .nrst, .actValid, .actInfo, .chainAllow, .cfgInfo, .cfgChain,
		.cfgEnd, .actReady, .infoLoad, .infoData, .doneValid, .doneData, .chainSeen, .actCnt,
		.fetchCnt, .doneCnt);
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= TCX_HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic go(input int k);
		int d;
		int a;
		bus(TCX_OFS_ENABLE_A, 1'b0, '0);
		bus(TCX_OFS_ENABLE_A, 1'b1, 32'h1 << k);
		d = doneCnt;
		a = actCnt;
		srcReq[k] <= 1'b1;
		// A source that stays high after acceptance would start a second, unplanned transfer.
		for (int n = 0; n < 300 && actCnt == a; n++) @(posedge mclk);
		srcReq[k] <= 1'b0;
		for (int n = 0; n < 300 && doneCnt == d; n++) @(posedge mclk);
		repeat (6) @(posedge mclk);
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		errTotal++;
		results();
	end
	initial begin
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 10; i++) begin
			bus(8'(4 * i), 1'b0, '0);
			`CHK(rd, 32'h0)
		end
		bus(TCX_OFS_ENABLE_H, 1'b1, 32'hFFFF);
		bus(TCX_OFS_ENABLE_H, 1'b1, 32'h0);
		bus(TCX_OFS_ENABLE_H, 1'b0, '0);
		`CHK(rd, 32'h0000FFFF)
		bus(TCX_OFS_ENABLE_H, 1'b1, 32'h7FFF);
		bus(TCX_OFS_ENABLE_H, 1'b0, '0);
		`CHK(rd, 32'h00007FFF)
		bus(TCX_OFS_CONTROL, 1'b1, 32'h1F);
		bus(TCX_OFS_CONTROL, 1'b0, '0);
		`CHK(rd, 32'h18)
		`CHK({hresp, hreadyout}, {TCX_HRESP_OKAY, 1'b1})
		bus(TCX_OFS_CONTROL, 1'b1, 32'h0);
		$display("test registers end");
		for (int e = 0; e < 2; e++) begin
			addrError <= (e == 0);
			nmiEvent <= (e == 1);
			@(posedge mclk);
			addrError <= 1'b0;
			nmiEvent <= 1'b0;
			bus(TCX_OFS_ENABLE_A, 1'b1, 32'h1);
			srcReq[0] <= 1'b1;
			a0 = actCnt;
			repeat (10) @(posedge mclk);
			`CHK({xferHalt, cpuSrcReq[0], 32'(actCnt - a0)}, {2'b10, 32'h0})
			srcReq[0] <= 1'b0;
			bus(TCX_OFS_CONTROL, 1'b0, '0);
			`CHK(rd, 32'h1)
			bus(TCX_OFS_CONTROL, 1'b1, 32'h0);
			bus(TCX_OFS_CONTROL, 1'b0, '0);
			`CHK(rd, 32'h0)
		end
		f0 = fetchCnt;
		go(0);
		bus(TCX_OFS_ENABLE_A, 1'b0, '0);
		`CHK({rd, 32'(fetchCnt - f0), 32'(irqCnt), 25'h0, irqVec}, {32'h0, 32'h1, 32'h1, 32'h0})
		$display("test stop end");
		for (int r = 0; r < 5; r++) begin
			bus(TCX_OFS_CONTROL, 1'b1, {24'h0, ctlTab[r]});
			cfgChain <= chnTab[r];
			cfgInfo.mode <= (r > 2) ? TCX_MODE_REPEAT : TCX_MODE_NORMAL;
			f0 = fetchCnt;
			go(0);
			`CHK(32'(fetchCnt - f0), 32'(fetTab[r]))
			if (chnTab[r]) `CHK(chainSeen, seeTab[r])
		end
		$display("test skip end");
		cfgChain <= 1'b0;
		cfgInfo <= '{TCX_MODE_NORMAL, 1'b0, 16'h0001};
		cfgEnd <= 1'b0;
		i0 = irqCnt;
		go(2);
		bus(TCX_OFS_ENABLE_A, 1'b0, '0);
		`CHK({rd, 32'(irqCnt - i0)}, {32'h4, 32'h0})
		cfgEnd <= 1'b1;
		go(2);
		bus(TCX_OFS_ENABLE_A, 1'b0, '0);
		`CHK({rd, 32'(irqCnt - i0), 25'h0, irqVec}, {32'h0, 32'h1, 32'h2})
		cfgInfo <= '{TCX_MODE_BLOCK, 1'b0, 16'h0003};
		cfgEnd <= 1'b0;
		a0 = actCnt;
		bus(TCX_OFS_ENABLE_A, 1'b1, 32'h2);
		srcReq[1] <= 1'b1;
		for (int n = 0; n < 400 && irqCnt == i0 + 1; n++) @(posedge mclk);
		srcReq[1] <= 1'b0;
		srcReq[5] <= 1'b1;
		repeat (4) @(posedge mclk);
		`CHK({32'(actCnt - a0), 25'h0, irqVec, cpuSrcReq[5]}, {32'h3, 32'h1, 1'b1})
		$display("test count end");
		results();
	end
endmodule
